/* pkg/asrp_pkg.sv */
// Purpose: Shared constants and types for the static RAM port host controller.
// Assumes: core_clk at 40 MHz; the memory is asynchronous and has no clock.
package asrp_pkg;

  localparam int unsigned ADDR_W       = 18;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned CLK_PS       = 1_000_000_000 / (CLK_HZ / 1000);
  localparam int unsigned CYCLE_NS     = 110;
  localparam int unsigned WPULSE_NS    = 85;
  localparam int unsigned ACCESS_NS    = 110;
  localparam int unsigned RECOVER_MS   = 5;
  // Cycle, write pulse and access least times round up to whole clock cycles; recovery divides down.
  localparam int unsigned CYCLE_CYC    = (CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned WPULSE_CYC   = (WPULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned ACCESS_CYC   = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RECOVER_CYC  = (RECOVER_MS * 1_000_000) / (CLK_PS / 1000);
  localparam int unsigned CNT_W        = 20;

  typedef enum logic [4:0] {
    ASRP_RECOVER = 5'h01,
    ASRP_IDLE    = 5'h02,
    ASRP_READ    = 5'h04,
    ASRP_WRITE   = 5'h08,
    ASRP_TAIL    = 5'h10
  } asrp_state_t;

  typedef struct packed {
    logic              sel_n;
    logic              sel;
    logic              wr_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } asrp_pins_t;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrp_req_t;

endpackage : asrp_pkg

/* hw/asrp_sync.sv */
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Input is asynchronous to core_clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module asrp_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : asrp_sync

/* hw/asrp_host.sv */
// Purpose: Host-side controller that runs byte reads and writes on an async static RAM.
// Assumes: One request at a time; the RAM is the only driver besides this block on dq.
// Notes:   Every access is a full cycle of fixed clock counts set from the package.
`timescale 1ns/1ps
module asrp_host
  import asrp_pkg::*;
#(
  parameter int unsigned RECOVER_CYCLES = RECOVER_CYC
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // User request port
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire asrp_req_t         req,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_data,
  // Supply restored pulse from power monitor
  input  wire logic              supply_restored,
  // Memory pins
  output asrp_pins_t             pins,
  input  wire logic [DATA_W-1:0] dq_in
);
  typedef struct packed {
    asrp_state_t       st;
    logic [CNT_W-1:0]  cnt;
    asrp_pins_t        pins;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
  } asrp_core_t;

  localparam logic [CNT_W-1:0] C_CYCLE = CNT_W'(CYCLE_CYC);
  localparam logic [CNT_W-1:0] C_WP    = CNT_W'(WPULSE_CYC);
  localparam logic [CNT_W-1:0] C_ACC   = CNT_W'(ACCESS_CYC);
  localparam logic [CNT_W-1:0] C_REC   = CNT_W'(RECOVER_CYCLES);

  asrp_core_t       s_reg;
  asrp_core_t       s_next;
  logic [DATA_W-1:0] dq_sync;

  asrp_sync #(.WIDTH(DATA_W)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .d        (dq_in),
    .q        (dq_sync)
  );

  function automatic asrp_pins_t idle_pins(input asrp_pins_t p);
    asrp_pins_t r;
    r       = p;
    r.sel_n = 1'b1;
    r.sel   = 1'b0;
    r.wr_n  = 1'b1;
    r.oe_n  = 1'b1;
    r.dq_oe = 1'b0;
    return r;
  endfunction : idle_pins

  always_comb begin
    s_next           = s_reg;
    s_next.rsp_valid = 1'b0;
    case (s_reg.st)
      ASRP_RECOVER: begin
        // Chip stays deselected throughout the retention recovery wait.
        s_next.pins = idle_pins(s_reg.pins);
        if (s_reg.cnt >= C_REC - 1'b1) begin
          s_next.st  = ASRP_IDLE;
          s_next.cnt = '0;
        end else begin
          s_next.cnt = s_reg.cnt + 1'b1;
        end
      end
      ASRP_IDLE: begin
        s_next.pins = idle_pins(s_reg.pins);
        s_next.cnt  = '0;
        if (supply_restored) begin
          s_next.st = ASRP_RECOVER;
        end else if (req_valid) begin
          s_next.pins.addr = req.addr;
          s_next.pins.sel_n = 1'b0;
          s_next.pins.sel   = 1'b1;
          if (req.wr) begin
            // Gate stays high so the RAM never fights our write data.
            s_next.pins.oe_n   = 1'b1;
            s_next.pins.wr_n   = 1'b0;
            s_next.pins.dq_out = req.wdata;
            s_next.pins.dq_oe  = 1'b1;
            s_next.st          = ASRP_WRITE;
          end else begin
            s_next.pins.oe_n  = 1'b0;
            s_next.pins.dq_oe = 1'b0;
            s_next.st         = ASRP_READ;
          end
        end
      end
      ASRP_READ: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        // Two extra cycles cover the synchroniser delay on dq.
        if (s_reg.cnt == C_ACC + 1'b1) begin
          s_next.rsp_data  = dq_sync;
          s_next.rsp_valid = 1'b1;
          s_next.pins      = idle_pins(s_reg.pins);
          s_next.st        = ASRP_IDLE;
        end
      end
      ASRP_WRITE: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == C_WP - 1'b1) begin
          // Strobe rises first, so the RAM latches here while data still held.
          s_next.pins.wr_n = 1'b1;
          s_next.st        = ASRP_TAIL;
        end
      end
      ASRP_TAIL: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == C_CYCLE - 1'b1) begin
          s_next.pins = idle_pins(s_reg.pins);
          s_next.st   = ASRP_IDLE;
        end
      end
      default: begin
        s_next.st   = ASRP_IDLE;
        s_next.pins = idle_pins(s_reg.pins);
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg.st        <= ASRP_RECOVER;
      s_reg.cnt       <= '0;
      s_reg.pins      <= '{sel_n: 1'b1, sel: 1'b0, wr_n: 1'b1, oe_n: 1'b1,
                           addr: '0, dq_out: '0, dq_oe: 1'b0};
      s_reg.rsp_valid <= 1'b0;
      s_reg.rsp_data  <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins      = s_reg.pins;
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_data  = s_reg.rsp_data;
  assign req_ready = (s_reg.st == ASRP_IDLE) && !supply_restored;

  logic active;
  assign active = !s_reg.pins.sel_n && s_reg.pins.sel;

  property p_wr_qual;
    @(posedge core_clk) disable iff (!nrst)
      !s_reg.pins.wr_n |-> active && s_reg.pins.dq_oe;
  endproperty
  a_wr_qual: assert property (p_wr_qual) else $error("write strobe low while not selected");

  property p_addr_hold;
    @(posedge core_clk) disable iff (!nrst)
      active && $past(active) |-> $stable(s_reg.pins.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in a cycle");

  property p_data_hold;
    @(posedge core_clk) disable iff (!nrst)
      $rose(s_reg.pins.wr_n) && active |-> s_reg.pins.dq_oe && $stable(s_reg.pins.dq_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held at strobe rise");

  property p_oe_in_write;
    @(posedge core_clk) disable iff (!nrst)
      s_reg.pins.dq_oe |-> s_reg.pins.oe_n;
  endproperty
  a_oe_in_write: assert property (p_oe_in_write) else $error("gate low while host drives");

  property p_no_contend;
    @(posedge core_clk) disable iff (!nrst)
      !s_reg.pins.oe_n |-> !s_reg.pins.dq_oe && s_reg.pins.wr_n;
  endproperty
  a_no_contend: assert property (p_no_contend) else $error("host drives during read");

  sequence s_wr_start;
    $fell(s_reg.pins.wr_n);
  endsequence
  sequence s_wr_low;
    !s_reg.pins.wr_n [*4];
  endsequence
  property p_wpulse;
    @(posedge core_clk) disable iff (!nrst)
      s_wr_start |-> s_wr_low ##1 active [*1];
  endproperty
  a_wpulse: assert property (p_wpulse) else $error("write pulse too short");

  property p_rd_len;
    @(posedge core_clk) disable iff (!nrst)
      $fell(s_reg.pins.oe_n) |-> !s_reg.pins.oe_n [*6];
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read cycle too short");

  property p_recover;
    @(posedge core_clk) disable iff (!nrst)
      s_reg.st == ASRP_RECOVER |-> !active;
  endproperty
  a_recover: assert property (p_recover) else $error("selected during recovery");

endmodule : asrp_host

/* sim/asrp_ram_model.sv */
// Purpose: Behavioural static RAM on the far side of the port controller.
// Assumes: No clock; the model reacts to pin levels only.
// Notes:   Released data lines show the inverse of their last driven level.
`timescale 1ns/1ps
module asrp_ram_model
  import asrp_pkg::*;
#(
  parameter int ACC_NS = 110
) (
  // Pins from the host
  input  wire asrp_pins_t  pins,
  // Data line level and memory drive flag
  output logic [DATA_W-1:0] dq,
  output logic              drv
);
  logic [DATA_W-1:0] mem [0:262143];
  logic [DATA_W-1:0] last_dq = 8'h00;
  logic              wr_first = 1'b0;
  wire               chosen = !pins.sel_n && pins.sel;
  wire               wr_on = chosen && !pins.wr_n;
  wire [ADDR_W:0]    key = {chosen && pins.wr_n && !pins.oe_n, pins.addr};
  // Inertial delay: data is only valid once address and mode held for the access time.
  wire [ADDR_W:0] #(ACC_NS) key_d = key;

  always @(posedge chosen) wr_first = !pins.wr_n;
  always @(negedge wr_on) mem[pins.addr] = dq;
  assign drv = key[ADDR_W] && !wr_first;

  always @* begin
    if (pins.dq_oe) dq = pins.dq_out;
    else if (drv) dq = (key_d == key) ? mem[pins.addr] : ~mem[pins.addr];
    else dq = ~last_dq;
  end
  always @(pins.dq_oe or drv or dq) if (pins.dq_oe || drv) last_dq = dq;
endmodule : asrp_ram_model

/* sim/testbench.sv */
// Purpose: Self-checking bench for the static RAM port controller.
// Assumes: Recovery shortened to REC cycles.
// Notes:   Pin timing is watched on every falling edge while nrst is high.
`timescale 1ns/1ps
module testbench;
  import asrp_pkg::*;
  localparam int REC = 20;
  logic              core_clk;
  logic              nrst;
  logic              req_valid;
  logic              req_ready;
  asrp_req_t         req;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  logic              supply_restored;
  asrp_pins_t        pins;
  logic [DATA_W-1:0] dq;
  logic              drv;
  int                num_errors = 0;
  int                total_checks = 0;
  int                cycles = 0;
  int                slen = 0;
  int                wlow = 0;
  logic [17:0]       sel_addr;

  asrp_host #(.RECOVER_CYCLES(REC)) dut (.core_clk(core_clk), .nrst(nrst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .supply_restored(supply_restored), .pins(pins), .dq_in(dq));
  asrp_ram_model ram (.pins(pins), .dq(dq), .drv(drv));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Test addresses cover both ends and alternating bit patterns of the address bus.
  function automatic logic [17:0] ad(input int i);
    case (i)
      0:       ad = 18'h00000;
      1:       ad = 18'h3ffff;
      2:       ad = 18'h15555;
      default: ad = 18'h2aaaa;
    endcase
  endfunction : ad

  function automatic logic [7:0] pat(input int i);
    logic [17:0] a;
    a   = ad(i);
    pat = a[7:0] ^ 8'h5a;
  endfunction : pat

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic access(input logic wr, input logic [17:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    n = 0;
    @(negedge core_clk);
    req_valid = 1'b1;
    req = {wr, a, d};
    while (req_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    req_valid = 1'b0;
    while (!wr && rsp_valid !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    q = rsp_data;
    check("response", n < 20, 1);
  endtask : access

  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      check("deselected", {pins.sel_n, pins.sel}, 2'b10);
      @(negedge core_clk);
      n++;
    end
    check("recovery time", n >= REC, 1);
  endtask : wait_ready

  task automatic t_rw();
    logic [7:0] q;
    for (int i = 0; i < 4; i++) access(1'b1, ad(i), pat(i), q);
    access(1'b1, ad(1), 8'hc3, q);
    for (int i = 0; i < 4; i++) begin
      access(1'b0, ad(i), 8'h00, q);
      check("read byte", q, (i == 1) ? 8'hc3 : pat(i));
    end
  endtask : t_rw

  task automatic t_retention();
    logic [7:0] q;
    @(negedge core_clk);
    supply_restored = 1'b1;
    @(negedge core_clk);
    supply_restored = 1'b0;
    check("ready in recovery", req_ready, 1'b0);
    wait_ready();
    access(1'b0, ad(2), 8'h00, q);
    check("retained byte", q, pat(2));
  endtask : t_retention

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end

  always @(negedge core_clk) if (nrst) begin
    if (pins.dq_oe && drv) check("contention", 1, 0);
    if (!pins.wr_n) check("gate in write", pins.oe_n, 1'b1);
    if (!pins.sel_n && pins.sel) begin
      if (slen != 0) check("address held", pins.addr, sel_addr);
      sel_addr = pins.addr;
      slen++;
      wlow += !pins.wr_n;
    end else if (slen != 0) begin
      check("cycle length", slen >= (110 + 24) / 25, 1);
      if (wlow != 0) check("strobe length", wlow >= (85 + 24) / 25, 1);
      slen = 0;
      wlow = 0;
    end
  end

  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    supply_restored = 1'b0;
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    wait_ready();
    t_rw();
    t_retention();
    end_of_test();
  end
endmodule : testbench
